// ### logic/sbc_params.svh
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
// register byte offsets on the configuration port
`define SBC_ADDR_DATA 8'hb0
`define SBC_ADDR_INDEX 8'hb1
`define SBC_ADDR_SLAVE 8'hb2
`define SBC_ADDR_CTRL 8'hb3
// control/status field positions
`define SBC_BIT_PSEL 7
`define SBC_BIT_ROME 0
`define SBC_BIT_REQE 1
`define SBC_BIT_TEST 2
`define SBC_BIT_DET 3
// reset values
`define SBC_CTRL_RESET 8'h00
`define SBC_DATA_RESET 8'h00
// timing: quarter of a serial clock period
`define SBC_CLK_NS 10
`define SBC_QTR_NS 2500
`define SBC_QTR_FAST_NS 250
`define SBC_QTR_CYC (`SBC_QTR_NS / `SBC_CLK_NS)
`define SBC_QTR_FAST_CYC (`SBC_QTR_FAST_NS / `SBC_CLK_NS)
// settle time before the clock-line pullup is sampled
`define SBC_DET_NS 1000
`define SBC_DET_CYC (`SBC_DET_NS / `SBC_CLK_NS)
// auto-load source and format
`define SBC_EE_ADDR 7'h50
`define SBC_EE_INDEX 8'h00
`define SBC_EE_HDR 8'ha5
`define SBC_EE_LAST 2'h2
`endif

// ### logic/sbc_pkg.sv
package sbc_pkg;
  // engine states
  typedef enum logic [2:0] {
    SBC_DETECT, SBC_IDLE, SBC_START, SBC_TX, SBC_RX, SBC_STOP
  } sbc_state_t;
  // what follows an acknowledged transmitted byte
  typedef enum logic [1:0] {
    SBC_NEXT_TX, SBC_RESTART, SBC_GO_RX, SBC_GO_STOP
  } sbc_act_t;
  // complete block state
  typedef struct packed {
    sbc_state_t st;
    logic [8:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] k;
    logic [1:0] rxcnt;
    logic nack;
    logic is_rd;
    logic short_p;
    logic is_load;
    logic [7:0] shreg;
    logic busy;
    logic rom_busy;
    logic [7:0] data;
    logic [7:0] index;
    logic [7:0] slave;
    logic psel;
    logic det;
    logic test;
    logic req_err;
    logic rom_err;
    logic [15:0] sub_id;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic s_scl1;
    logic s_scl2;
    logic s_sda1;
    logic s_sda2;
    logic [7:0] detcnt;
  } sbc_regs_t;
endpackage

// ### logic/sbc_serial_bus_ctrl.sv
// How it works
// - short select: send-byte writes, receive-byte reads
// - short select: index byte never sent
// - slave-address write launches, busy set at once
// - busy held while transfer in progress
// - read byte stored before busy clears
// - eeprom busy flag high during auto-load
// - after reset, clock pullup sets detect bit
// - about 100 kHz, faster when test set
// - missing ack on request sets request error
// - request error cleared by writing one
// - missing ack during auto-load sets load error
// - bad eeprom format sets load error
// - load error cleared by writing one
// - bit six always reads zero
// - sticky bits survive partial reset; global reset clears them
// - slave register: address 7..1, direction bit 0
// - data and index registers feed the transfer
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_serial_bus_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic partial_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic eeprom_load_busy,
  output logic [15:0] subsystem_id
);
  import sbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // next step after an acknowledged byte
  function automatic sbc_act_t next_act(input logic [1:0] k,
                                        input logic rd, input logic sh);
    sbc_act_t a;
    a = SBC_GO_STOP;
    if (rd && sh)
      a = SBC_GO_RX;
    else if (rd)
      a = (k == 2'h0) ? SBC_NEXT_TX : (k == 2'h1) ? SBC_RESTART : SBC_GO_RX;
    else if (sh)
      a = (k == 2'h0) ? SBC_NEXT_TX : SBC_GO_STOP;
    else
      a = (k == 2'h2) ? SBC_GO_STOP : SBC_NEXT_TX;
    return a;
  endfunction

  // byte to shift out as byte k of the sequence
  function automatic logic [7:0] tx_byte(input logic [1:0] k,
      input logic rd, input logic sh, input logic [6:0] adr,
      input logic [7:0] idx, input logic [7:0] dat);
    logic [7:0] b;
    b = {adr, rd & sh};
    if (k == 2'h1)
      b = sh ? dat : idx;
    else if (k == 2'h2)
      b = rd ? {adr, 1'b1} : dat;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  localparam sbc_regs_t RST = '{st: SBC_DETECT, data: `SBC_DATA_RESET,
    index: `SBC_DATA_RESET, slave: `SBC_DATA_RESET, default: '0};
  localparam logic [8:0] QN = 9'(`SBC_QTR_CYC);
  localparam logic [8:0] QF = 9'(`SBC_QTR_FAST_CYC);
  localparam logic [7:0] DC = 8'(`SBC_DET_CYC);
  sbc_regs_t r; // registered state
  sbc_regs_t n; // next state
  logic tick; // end of a quarter bit
  logic end3; // end of a whole bit
  logic [6:0] adr; // target address in use
  logic [7:0] idx; // byte address in use
  logic [7:0] rxb; // byte with newest bit in
  logic [7:0] ctrl; // control/status read view

  // quarter length follows the test bit
  assign tick = r.qcnt == ((r.test ? QF : QN) - 9'h001);
  assign end3 = tick && (r.q == 2'h3);
  assign adr = r.is_load ? `SBC_EE_ADDR : r.slave[7:1];
  assign idx = r.is_load ? `SBC_EE_INDEX : r.index;
  assign rxb = {r.shreg[6:0], r.s_sda2};
  // reserved bit six wired to zero
  assign ctrl = {r.psel, 1'b0, r.busy, r.rom_busy, r.det, r.test,
                 r.req_err, r.rom_err};

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    n = r;
    // two-flop synchronisers for the pins
    n.s_scl1 = scl_in;
    n.s_scl2 = r.s_scl1;
    n.s_sda1 = sda_in;
    n.s_sda2 = r.s_sda1;
    // quarter timer runs only while the engine works
    if (tick || r.st == SBC_IDLE || r.st == SBC_DETECT)
      n.qcnt = 9'h000;
    else
      n.qcnt = r.qcnt + 9'h001;
    if (tick)
      n.q = r.q + 2'h1;
    // register writes; sticky clears come before engine sets
    if (reg_wr)
    begin
      case (reg_addr)
        `SBC_ADDR_DATA:
          if (!r.busy)
            n.data = reg_wdata;
        `SBC_ADDR_INDEX:
          if (!r.busy)
            n.index = reg_wdata;
        `SBC_ADDR_SLAVE:
          // launch; a write during a transfer is dropped
          if (!r.busy)
          begin
            n.slave = reg_wdata;
            n.busy = 1'b1;
          end
        `SBC_ADDR_CTRL:
        begin
          n.psel = reg_wdata[`SBC_BIT_PSEL];
          n.det = reg_wdata[`SBC_BIT_DET];
          n.test = reg_wdata[`SBC_BIT_TEST];
          if (reg_wdata[`SBC_BIT_REQE])
            n.req_err = 1'b0;
          if (reg_wdata[`SBC_BIT_ROME])
            n.rom_err = 1'b0;
        end
        default:
          n.rdata = r.rdata; // unmapped writes ignored
      endcase
    end
    // registered read data, unmapped reads zero
    if (reg_rd)
    begin
      case (reg_addr)
        `SBC_ADDR_DATA: n.rdata = r.data;
        `SBC_ADDR_INDEX: n.rdata = r.index;
        `SBC_ADDR_SLAVE: n.rdata = r.slave;
        `SBC_ADDR_CTRL: n.rdata = ctrl;
        default: n.rdata = 8'h00;
      endcase
    end
    // serial engine
    case (r.st)
      SBC_DETECT:
      begin
        // let the pullup settle, then sample the clock line
        n.detcnt = r.detcnt + 8'h01;
        if (r.detcnt == DC - 8'h01)
        begin
          n.det = r.s_scl2;
          n.st = r.s_scl2 ? SBC_START : SBC_IDLE;
          n.rom_busy = r.s_scl2;
          n.is_load = r.s_scl2;
          n.is_rd = 1'b1;
          n.short_p = 1'b0;
          n.k = 2'h0;
          n.rxcnt = 2'h0;
        end
      end
      SBC_IDLE:
      begin
        n.q = 2'h0;
        // a pending request starts once the bus is free
        if (r.busy)
        begin
          n.st = SBC_START;
          n.is_rd = r.slave[0];
          n.short_p = r.psel;
          n.k = 2'h0;
          n.rxcnt = 2'h0;
        end
      end
      SBC_START:
      begin
        // data falls while the clock is high
        n.scl_oe = r.q == 2'h0;
        n.sda_oe = r.q[1];
        if (end3)
        begin
          n.st = SBC_TX;
          n.bitn = 4'h0;
          n.shreg = tx_byte(r.k, r.is_rd, r.short_p, adr, idx, r.data);
        end
      end
      SBC_TX:
      begin
        n.scl_oe = !r.q[1];
        // data moves only once the clock has been low a cycle, so a
        // bit change can never pose as a start or stop
        if (r.scl_oe)
          n.sda_oe = (r.bitn != 4'h8) && !r.shreg[7];
        if (end3)
        begin
          if (r.bitn != 4'h8)
          begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.bitn = r.bitn + 4'h1;
          end
          else if (r.s_sda2)
          begin
            // no acknowledge: flag it and give the bus back
            if (r.is_load)
              n.rom_err = 1'b1;
            else
              n.req_err = 1'b1;
            n.st = SBC_STOP;
          end
          else
          begin
            n.k = r.k + 2'h1;
            n.bitn = 4'h0;
            case (next_act(r.k, r.is_rd, r.short_p))
              SBC_NEXT_TX:
                n.shreg = tx_byte(r.k + 2'h1, r.is_rd, r.short_p, adr, idx,
                                  r.data);
              SBC_RESTART: n.st = SBC_START;
              SBC_GO_RX: n.st = SBC_RX;
              default: n.st = SBC_STOP;
            endcase
          end
        end
      end
      SBC_RX:
      begin
        n.scl_oe = !r.q[1];
        // same hold as on transmit: ack moves behind the clock fall
        if (r.scl_oe)
          n.sda_oe = (r.bitn == 4'h8) && !r.nack;
        if (end3)
        begin
          if (r.bitn != 4'h8)
          begin
            n.shreg = rxb;
            n.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h7)
            begin
              // last byte or bad header ends with no acknowledge
              n.nack = !r.is_load || r.rxcnt == `SBC_EE_LAST ||
                       (r.rxcnt == 2'h0 && rxb != `SBC_EE_HDR);
              if (r.is_load && r.rxcnt == 2'h0 && rxb != `SBC_EE_HDR)
                n.rom_err = 1'b1;
            end
          end
          else
          begin
            if (!r.is_load)
              n.data = r.shreg;
            else if (r.rxcnt == 2'h1)
              n.sub_id[7:0] = r.shreg;
            else if (r.rxcnt == 2'h2)
              n.sub_id[15:8] = r.shreg;
            n.bitn = 4'h0;
            n.rxcnt = r.rxcnt + 2'h1;
            if (r.nack)
              n.st = SBC_STOP;
          end
        end
      end
      SBC_STOP:
      begin
        // data rises while the clock is high
        n.scl_oe = r.q == 2'h0;
        // pull data low only after the clock is already low
        n.sda_oe = (r.q == 2'h0) ? r.scl_oe : !r.q[1];
        if (end3)
        begin
          n.st = SBC_IDLE;
          n.busy = r.is_load ? r.busy : 1'b0;
          n.rom_busy = 1'b0;
          n.is_load = 1'b0;
        end
      end
      default:
        n.st = SBC_IDLE;
    endcase
    // partial reset aborts the engine unless it is in bus detect; sticky bits survive
    if (partial_reset)
    begin
      if (r.st != SBC_DETECT)
        n.st = SBC_IDLE;
      n.busy = 1'b0;
      n.rom_busy = 1'b0;
      n.is_load = 1'b0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; global reset clears sticky bits, partial reset does not
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      r <= RST;
    else
      r <= n;
  end

  // open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;
  assign reg_rdata = r.rdata;
  assign eeprom_load_busy = r.rom_busy;
  assign subsystem_id = r.sub_id;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_launch;
    reg_wr && reg_addr == `SBC_ADDR_SLAVE && !r.busy && !partial_reset
      |=> r.busy;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch did not set busy");

  property p_hold;
    r.busy && !(r.st == SBC_STOP && end3) && !partial_reset |=> r.busy;
  endproperty
  a_hold: assert property (p_hold)
    else $error("busy dropped mid transfer");

  property p_shortrd;
    r.st == SBC_START && end3 && r.short_p && r.is_rd && !r.is_load &&
      !partial_reset |=> r.st == SBC_TX && r.shreg[0];
  endproperty
  a_shortrd: assert property (p_shortrd)
    else $error("short read sent no read bit");

  property p_noidx;
    r.st == SBC_TX && r.short_p && r.is_rd && !r.is_load |-> r.k == 2'h0;
  endproperty
  a_noidx: assert property (p_noidx)
    else $error("index sent in short mode");

  property p_reqerr;
    r.st == SBC_TX && end3 && r.bitn == 4'h8 && r.s_sda2 && !r.is_load
      |=> r.req_err && (r.st == SBC_STOP || r.st == SBC_IDLE);
  endproperty
  a_reqerr: assert property (p_reqerr)
    else $error("request nack not flagged");

  property p_romerr;
    r.st == SBC_TX && end3 && r.bitn == 4'h8 && r.s_sda2 && r.is_load
      |=> r.rom_err;
  endproperty
  a_romerr: assert property (p_romerr)
    else $error("load nack not flagged");

  property p_w1c;
    reg_wr && reg_addr == `SBC_ADDR_CTRL && !reg_wdata[`SBC_BIT_REQE] &&
      r.req_err |=> r.req_err;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("request error lost on write of zero");

  property p_rsvd;
    reg_rd && reg_addr == `SBC_ADDR_CTRL |=> !reg_rdata[6];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit read as one");

  property p_release;
    r.st == SBC_STOP && end3 && !r.is_load && !partial_reset
      |=> !r.busy && !r.scl_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("stop did not end request");

  c_read: cover property ($fell(r.busy) && r.is_rd);
  c_write: cover property ($fell(r.busy) && !r.is_rd);
  c_load: cover property ($fell(r.rom_busy) && !r.rom_err);
endmodule // sbc_serial_bus_ctrl

// ### testbench/sbc_eeprom_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// two-wire eeprom stand-in at address 0x50
// acks its address, logs written bytes, serves reads
module sbc_eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic [7:0] hdr,
  output logic sda_oe
);
  logic [7:0] sh, ptr, tx; // shifter, byte pointer, byte on its way out
  logic [7:0] log_q[$]; // bytes taken after a write address
  logic first = 0, sel = 0, rd = 0, mack = 0, got_idx = 0;
  int bitc = 0; // clock highs seen in this byte
  initial
    sda_oe = 0;
  // content: header, id low, id high, then a pattern
  function automatic logic [7:0] mem(input logic [7:0] a);
    return a == 0 ? hdr : a == 1 ? 8'h34 : a == 2 ? 8'h12 : a ^ 8'h5a;
  endfunction
  // start or repeated start: next byte is an address
  always @(negedge sda)
    if (scl)
    begin
      first = 1;
      bitc = 0;
      sda_oe = 0;
    end
  // stop ends any selection
  always @(posedge sda)
    if (scl)
      sel = 0;
  // bits and the master's ack are taken while the clock is high
  always @(posedge scl)
  begin
    if (bitc < 8)
      sh = {sh[6:0], sda};
    else
      mack = !sda;
    bitc++;
  end
  // the data line only moves while the clock is low
  always @(negedge scl)
  begin
    if (bitc > 0 && bitc < 8 && sel && rd)
      sda_oe = !tx[7 - bitc];
    else if (bitc == 8)
    begin
      sda_oe = 0;
      if (first)
      begin
        sel = sh[7:1] == 7'h50 && ack_en;
        rd = sh[0];
        got_idx = 0;
        sda_oe = sel;
      end
      else if (sel && !rd)
      begin
        // first written byte moves the pointer, as a real part does
        if (!got_idx)
          ptr = sh;
        got_idx = 1;
        log_q.push_back(sh);
        sda_oe = 1;
      end
      first = 0;
    end
    else if (bitc == 9)
    begin
      bitc = 0;
      sda_oe = 0;
      // keep sending only while the master acks, else let go for stop
      if (sel && rd && mack)
      begin
        tx = mem(ptr);
        ptr++;
        sda_oe = !tx[7];
      end
      else if (rd)
        sel = 0;
    end
  end
endmodule // sbc_eeprom_model

// ### testbench/sbc_serial_bus_ctrl_tb.sv
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_serial_bus_ctrl_tb;
  logic ref_clk = 0, reset = 1, partial_reset = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, hdr = 8'ha5, rv;
  logic pull_on = 1, ack_en = 1, scl_oe, sda_oe, m_oe, eeprom_load_busy;
  logic [7:0] reg_rdata;
  logic [15:0] subsystem_id;
  int num_errors = 0, n_compared = 0;
  // open-drain lines; clock pullup can be left off to hide the bus
  wire scl_w = pull_on & !scl_oe;
  wire sda_w = !(sda_oe | m_oe);
  // 100 MHz
  always #5 ref_clk = !ref_clk;
  sbc_serial_bus_ctrl u_sbc_serial_bus_ctrl (
    .ref_clk(ref_clk), .reset(reset), .partial_reset(partial_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
    .eeprom_load_busy(eeprom_load_busy), .subsystem_id(subsystem_id)
  );
  sbc_eeprom_model u_sbc_eeprom_model (
    .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .hdr(hdr), .sda_oe(m_oe)
  );
  ////////////////////////////////////////////////////////////
  // closing report, the only exit
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up();
    num_errors++;
    $display("Error timeout waiting on the block");
    end_sim();
  endtask
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  // read data is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(posedge ref_clk);
    rv = reg_rdata;
  endtask
  // poll the transfer busy bit, bounded
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++)
    begin
      rd(`SBC_ADDR_CTRL);
      if (rv[5] === 1'b0)
        return;
    end
    give_up();
  endtask
  ////////////////////////////////////////////////////////////
  // global reset, bus detect and auto-load at the fast test clock
  task automatic boot(input logic p, a, input logic [7:0] h, e);
    reset <= 1;
    pull_on <= p;
    ack_en <= a;
    hdr <= h;
    repeat (20) @(posedge ref_clk);
    reset <= 0;
    rd(`SBC_ADDR_CTRL);
    chk("ctrl after reset", rv, 8'h00);
    wr(`SBC_ADDR_CTRL, 8'h04);
    repeat (150) @(posedge ref_clk);
    chk("load busy pin", {7'h0, eeprom_load_busy}, {7'h0, p});
    rd(`SBC_ADDR_CTRL);
    chk("ctrl during load", rv, {3'h0, p, p, 3'h4});
    for (int i = 0; i < 20000 && eeprom_load_busy !== 1'b0; i++)
      @(negedge ref_clk);
    if (eeprom_load_busy !== 1'b0)
      give_up();
    rd(`SBC_ADDR_CTRL);
    chk("ctrl after load", rv, e);
    wr(`SBC_ADDR_CTRL, rv);
    rd(`SBC_ADDR_CTRL);
    chk("load error cleared", rv, e & 8'hfe);
  endtask
  // load data and index, then launch through the slave address
  task automatic xfer(input logic [7:0] ctl, idx, dat, sa, n, b0, ex);
    wr(`SBC_ADDR_CTRL, ctl);
    u_sbc_eeprom_model.log_q.delete();
    wr(`SBC_ADDR_DATA, dat);
    wr(`SBC_ADDR_INDEX, idx);
    wr(`SBC_ADDR_SLAVE, sa);
    rd(`SBC_ADDR_CTRL);
    chk("busy at launch", rv & 8'h20, 8'h20);
    wait_idle();
    chk("bytes sent", 8'(u_sbc_eeprom_model.log_q.size()), n);
    if (n > 0)
      chk("first byte sent", u_sbc_eeprom_model.log_q[0], b0);
    rd(`SBC_ADDR_DATA);
    chk("data register", rv, ex);
  endtask
  // nobody acks: request error set, cleared only by writing one
  task automatic t_nack();
    ack_en <= 0;
    xfer(8'h0c, 8'h10, 8'h77, 8'ha0, 8'h0, 8'h0, 8'h77);
    rd(`SBC_ADDR_CTRL);
    chk("request error", rv, 8'h0e);
    wr(`SBC_ADDR_CTRL, 8'h0c);
    rd(`SBC_ADDR_CTRL);
    chk("error kept on zero", rv, 8'h0e);
    wr(`SBC_ADDR_CTRL, 8'h0e);
    rd(`SBC_ADDR_CTRL);
    chk("error cleared on one", rv, 8'h0c);
    ack_en <= 1;
  endtask
  // clock period between pull-downs, then a partial reset mid-byte
  task automatic t_rate(input logic [7:0] ctl, input int q);
    int n = 0;
    int t[3];
    logic p = 0;
    wr(`SBC_ADDR_CTRL, ctl);
    wr(`SBC_ADDR_SLAVE, 8'ha0);
    for (int i = 0; i < 5000 && n < 3; i++)
    begin
      // look between edges, where the pin drive has settled
      @(negedge ref_clk);
      if (scl_oe === 1'b1 && !p)
        t[n++] = i;
      p = scl_oe;
    end
    if (n < 3)
      give_up();
    chk("clock period", 8'((t[2] - t[1]) / 10), 8'(4 * q / 10));
    rd(`SBC_ADDR_CTRL);
    chk("busy mid transfer", rv, ctl | 8'h20);
    partial_reset <= 1;
    @(posedge ref_clk);
    partial_reset <= 0;
    rd(`SBC_ADDR_CTRL);
    chk("after partial reset", rv, ctl);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    boot(0, 1, 8'ha5, 8'h04);
    boot(1, 1, 8'h3c, 8'h0d);
    boot(1, 0, 8'ha5, 8'h0d);
    boot(1, 1, 8'ha5, 8'h0c);
    chk("id low", subsystem_id[7:0], 8'h34);
    chk("id high", subsystem_id[15:8], 8'h12);
    xfer(8'h0c, 8'h10, 8'h77, 8'ha0, 8'h2, 8'h10, 8'h77);
    xfer(8'h8c, 8'h10, 8'h66, 8'ha0, 8'h1, 8'h66, 8'h66);
    xfer(8'h0c, 8'h05, 8'h00, 8'ha1, 8'h1, 8'h05, 8'h5f);
    xfer(8'h8c, 8'h05, 8'h00, 8'ha1, 8'h0, 8'h00, 8'h5c);
    t_nack();
    t_rate(8'h0c, 25);
    t_rate(8'h08, 250);
    end_sim();
  end
endmodule // sbc_serial_bus_ctrl_tb
